/* hdl/analog_ctrl_pkg.sv */
package analog_ctrl_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MUX    = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ    = 4'hC;
  // ----------------------------------------------------------------
  // analog multiplex register fields
  // ----------------------------------------------------------------
  localparam int MUX_CH_LSB = 0;
  localparam int MUX_CH_W   = 4;
  localparam int MUX_VREF   = 4;
  localparam int MUX_HOLD   = 5;
  localparam int MUX_DIV_HOLD = 6;
  // ----------------------------------------------------------------
  // analog control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_METH_A = 0;
  localparam int CTRL_METH_B = 1;
  localparam int CTRL_CHARGE = 2;
  localparam int CTRL_RAMP_EN = 3;
  localparam int CTRL_CMP_OE = 4;
  localparam int CTRL_WAIT   = 5;
  localparam int CTRL_STOP   = 6;
  // ----------------------------------------------------------------
  // status / interrupt bits
  // ----------------------------------------------------------------
  localparam int ST_CMP1  = 0;
  localparam int ST_CMP2  = 1;
  localparam int ST_W     = 2;
  localparam int REG_W    = 8;
  localparam logic [REG_W-1:0] RST_VAL = 8'h00;
  // ----------------------------------------------------------------
  // channel source selection
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_NONE   = 3'h0,
    SRC_PIN    = 3'h1,
    SRC_SUPPLY = 3'h3,
    SRC_DIODE  = 3'h2
  } src_type;
endpackage

/* hdl/analog_sel_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface analog_sel_if;
  logic [7:0] mux_reg;
  logic [3:0] pin_sw;
  logic       supply_sw;
  logic       divide_sw;
  logic       diode_sw;
  modport ctl (output mux_reg, input pin_sw, supply_sw, divide_sw, diode_sw);
  modport dec (input mux_reg, output pin_sw, supply_sw, divide_sw, diode_sw);
endinterface
`default_nettype wire

/* hdl/analog_sel_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_sel_decode
  import analog_ctrl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  analog_sel_if.dec sel
);
  logic [3:0] ch;
  logic       dia;
  assign ch  = sel.mux_reg[MUX_CH_LSB +: MUX_CH_W];
  assign dia = sel.mux_reg[MUX_HOLD] & sel.mux_reg[MUX_DIV_HOLD];
  // ----------------------------------------------------------------
  // registered switch controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel.pin_sw    <= 4'h0;
      sel.supply_sw <= 1'b0;
      sel.divide_sw <= 1'b0;
      sel.diode_sw  <= 1'b0;
    end
    else
    begin
      sel.pin_sw    <= dia ? 4'h0 : ch;
      sel.supply_sw <= !dia && sel.mux_reg[MUX_VREF] && ch == 4'h0;
      sel.divide_sw <= !dia && sel.mux_reg[MUX_DIV_HOLD];
      sel.diode_sw  <= dia;
    end
  end
endmodule // analog_sel_decode
`default_nettype wire

/* hdl/analog_mux_comparator_control.sv */
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module analog_mux_comparator_control
  import analog_ctrl_pkg::*;
#(
  parameter bit MASK_CMP_OUT = 1'b1
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        cmp1_i,
  input  wire logic        cmp2_i,
  input  wire logic        port_b4_data_i,
  input  wire logic        timer_output_level_i,
  input  wire logic        wait_mode_i,
  input  wire logic        stop_mode_i,
  output logic [3:0]       pin_channel_select_o,
  output logic             supply_select_o,
  output logic             divided_sample_select_o,
  output logic             diode_select_o,
  output logic             diode_bias_en_o,
  output logic             charge_source_en_o,
  output logic             discharge_en_o,
  output logic             compare_output_pin_o,
  output logic             compare_output_pin_oe_o,
  output logic             capture_input_o,
  output logic             wake_o,
  output logic             irq_o
);
  // ----------------------------------------------------------------
  // sizes and elaboration-time checks
  // ----------------------------------------------------------------
  localparam int NUM_CMP = 2;
  localparam int SYNC_W  = 2;
  localparam int BUS_W   = 32;
  localparam int CMP_ONE = 0;
  localparam int CMP_TWO = 1;
  localparam logic [REG_W-1:0] ST_MASK = (REG_W'(1) << ST_CMP1) | (REG_W'(1) << ST_CMP2);

  if (REG_W < 8 || REG_W > BUS_W)
  begin : g_reg_w_check
    $error("register width does not fit the bus");
  end
  if (ST_CMP1 >= REG_W || ST_CMP2 >= REG_W)
  begin : g_status_check
    $error("status bits fall outside the register");
  end
  if (SYNC_W < 2)
  begin : g_sync_check
    $error("pin synchronisers need two stages");
  end
  if (NUM_CMP != 2)
  begin : g_cmp_check
    $error("status layout serves exactly two comparators");
  end

  // ----------------------------------------------------------------
  // storage and internal nets
  // ----------------------------------------------------------------
  logic [REG_W-1:0]   mux_q;
  logic [REG_W-1:0]   ctrl_q;
  logic [REG_W-1:0]   stat_q;
  logic [REG_W-1:0]   mask_q;
  logic [REG_W-1:0]   rdat;
  logic [REG_W-1:0]   wdat;
  logic [REG_W-1:0]   ev;
  logic [REG_W-1:0]   pend;
  logic [NUM_CMP-1:0] cmp_raw;
  logic [NUM_CMP-1:0] cmp_sync;
  logic [NUM_CMP-1:0] cmp_rise;
  logic [SYNC_W-1:0]  wait_s_q;
  logic [SYNC_W-1:0]  stop_s_q;
  logic               wait_sync;
  logic               stop_sync;
  logic               req;
  logic               wr;
  logic [3:0]         reg_adr;
  logic               hit_mux;
  logic               hit_ctrl;
  logic               hit_status;
  logic               hit_mask;
  logic               ramp_on;
  logic               auto_mode;
  logic               manual_mode;
  logic               charge_req;
  logic               discharge_req;
  logic               cmp_pin_level;

  // ----------------------------------------------------------------
  // channel selection decode
  // ----------------------------------------------------------------
  // the decode flops own the switch controls, so they move one edge after the write
  analog_sel_if sel ();

  assign sel.mux_reg = mux_q;

  analog_sel_decode u_dec (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sel   (sel)
  );

  // ----------------------------------------------------------------
  // wishbone slave, one-wait answer
  // ----------------------------------------------------------------
  // the low ack gate stops one long strobe from being taken twice
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign reg_adr = wb_adr_i[3:0];
  assign wr      = req && wb_we_i && wb_sel_i[0];
  assign wdat    = wb_dat_i[REG_W-1:0];

  assign hit_mux    = reg_adr == ADDR_MUX;
  assign hit_ctrl   = reg_adr == ADDR_CTRL;
  assign hit_status = reg_adr == ADDR_STATUS;
  assign hit_mask   = reg_adr == ADDR_IRQ;

  always_comb
  begin
    case (reg_adr)
      ADDR_MUX:    rdat = mux_q;
      ADDR_CTRL:   rdat = ctrl_q;
      ADDR_STATUS: rdat = stat_q;
      ADDR_IRQ:    rdat = mask_q;
      default:     rdat = RST_VAL;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // only the low lane carries register data; the rest reads as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req)
      wb_dat_o <= {{(BUS_W-REG_W){1'b0}}, rdat};
  end

  // ----------------------------------------------------------------
  // control registers; selection held between writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mux_q <= RST_VAL;
    else if (wr && hit_mux)
      mux_q <= wdat;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= RST_VAL;
    else if (wr && hit_ctrl)
      ctrl_q <= wdat;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_q <= RST_VAL;
    else if (wr && hit_mask)
      mask_q <= wdat & ST_MASK;
  end

  // ----------------------------------------------------------------
  // comparator synchronisers and edge events
  // ----------------------------------------------------------------
  // comparators run on in wait and stop; only their rising edges are recorded
  assign cmp_raw = {cmp2_i, cmp1_i};

  for (genvar g = 0; g < NUM_CMP; g++)
  begin : g_cmp
    logic [SYNC_W-1:0] s_q;
    logic              p_q;

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        s_q <= '0;
      else
        s_q <= {s_q[SYNC_W-2:0], cmp_raw[g]};
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        p_q <= 1'b0;
      else
        p_q <= s_q[SYNC_W-1];
    end

    assign cmp_sync[g] = s_q[SYNC_W-1];
    assign cmp_rise[g] = s_q[SYNC_W-1] && !p_q;
  end

  // ----------------------------------------------------------------
  // low-power mode synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wait_s_q <= '0;
    else
      wait_s_q <= {wait_s_q[SYNC_W-2:0], wait_mode_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stop_s_q <= '0;
    else
      stop_s_q <= {stop_s_q[SYNC_W-2:0], stop_mode_i};
  end

  assign wait_sync = wait_s_q[SYNC_W-1];
  assign stop_sync = stop_s_q[SYNC_W-1];

  // ----------------------------------------------------------------
  // sticky status
  // ----------------------------------------------------------------
  always_comb
  begin
    ev = RST_VAL;
    ev[ST_CMP1] = cmp_rise[CMP_ONE];
    ev[ST_CMP2] = cmp_rise[CMP_TWO];
  end

  // a new event outranks the clearing write, so no edge is ever lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_q <= RST_VAL;
    else if (wr && hit_status)
      stat_q <= (stat_q & ~wdat) | ev;
    else
      stat_q <= stat_q | ev;
  end

  assign pend = stat_q & mask_q;

  // ----------------------------------------------------------------
  // ramp current control
  // ----------------------------------------------------------------
  // charge only in manual mode; the auto modes hand the pin to the discharge device
  assign ramp_on       = ctrl_q[CTRL_RAMP_EN];
  assign auto_mode     = ctrl_q[CTRL_METH_A] || ctrl_q[CTRL_METH_B];
  assign manual_mode   = !auto_mode;
  assign charge_req    = ramp_on && manual_mode && ctrl_q[CTRL_CHARGE];
  assign discharge_req = ramp_on && auto_mode;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  assign cmp_pin_level = cmp_sync[CMP_ONE] || port_b4_data_i || timer_output_level_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |pend;
  end

  // analog interrupt wakes from wait only, never from stop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_o <= 1'b0;
    else
      wake_o <= wait_sync && !stop_sync && |pend;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      charge_source_en_o <= 1'b0;
    else
      charge_source_en_o <= charge_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      discharge_en_o <= 1'b0;
    else
      discharge_en_o <= discharge_req;
  end

  // the pin level lags the comparator by the synchroniser stages plus the output flop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      compare_output_pin_o <= 1'b0;
    else
      compare_output_pin_o <= cmp_pin_level;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      compare_output_pin_oe_o <= 1'b0;
    else
      compare_output_pin_oe_o <= MASK_CMP_OUT && ctrl_q[CTRL_CMP_OE];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_input_o <= 1'b0;
    else
      capture_input_o <= cmp_sync[CMP_ONE];
  end

  // ----------------------------------------------------------------
  // switch controls
  // ----------------------------------------------------------------
  // decode flops already hold these, so no extra stage is added here
  assign pin_channel_select_o    = sel.pin_sw;
  assign supply_select_o         = sel.supply_sw;
  assign divided_sample_select_o = sel.divide_sw;
  assign diode_select_o          = sel.diode_sw;
  assign diode_bias_en_o         = sel.diode_sw;
endmodule // analog_mux_comparator_control
`default_nettype wire

/* sim/analog_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_ctrl_assertions
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0]  pin_channel_select_o,
  input wire logic        supply_select_o,
  input wire logic        divided_sample_select_o,
  input wire logic        diode_select_o,
  input wire logic        diode_bias_en_o,
  input wire logic        stop_mode_i,
  input wire logic        wake_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------
  // steps
  // ------------------------------------------------
  sequence wr_taken; wb_ack_o && wb_we_i; endsequence
  sequence stop_held; stop_mode_i [*4]; endsequence
  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  bias_follows_diode_a: assert property (diode_bias_en_o == diode_select_o) else $error("bias wrong");
  diode_alone_a: assert property (diode_select_o |-> !supply_select_o && pin_channel_select_o == 4'h0)
    else $error("diode not alone");
  switch_hold_a: assert property (!$stable({pin_channel_select_o, supply_select_o, divided_sample_select_o,
    diode_select_o}) |-> $past(wb_ack_o && wb_we_i)) else $error("switch moved");
  stop_no_wake_a: assert property (stop_held |-> !wake_o) else $error("stop wake");
  wake_needs_irq_a: assert property (wake_o |-> irq_o) else $error("wake without irq");
  write_seen_c: cover property (wr_taken);
endmodule // analog_ctrl_assertions
bind analog_mux_comparator_control analog_ctrl_assertions chk_u (.*);
`default_nettype wire

/* sim/analog_mux_comparator_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_mux_comparator_control_tb;
  import analog_ctrl_pkg::*;
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, pin_channel_select_o;
  logic        cmp1_i, cmp2_i, port_b4_data_i, timer_output_level_i, wait_mode_i, stop_mode_i;
  logic        supply_select_o, divided_sample_select_o, diode_select_o, diode_bias_en_o;
  logic        charge_source_en_o, discharge_en_o, compare_output_pin_o, compare_output_pin_oe_o;
  logic        capture_input_o, wake_o, irq_o;
  logic [7:0]  q;
  int          n_fail, check_count;
  logic [7:0]  mux_v [6] = '{8'h10, 8'h50, 8'h02, 8'h48, 8'h61, 8'h00};
  logic [7:0]  mux_e [6] = '{8'h08, 8'h0C, 8'h20, 8'h84, 8'h03, 8'h00};
  logic [7:0]  ctl_v [4] = '{8'h0C, 8'h08, 8'h0B, 8'h07};
  logic [1:0]  ctl_e [4] = '{2'h2, 2'h0, 2'h1, 2'h0};
  logic [1:0]  ctl_m [4] = '{2'h3, 2'h3, 2'h1, 2'h3};
  analog_mux_comparator_control dut_u (.*);
  always #25 clk_i = ~clk_i;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic we, input logic [7:0] d);
    int n;
    n = 0;
    wb_adr_i <= {28'h0, a};
    wb_we_i  <= we;
    wb_dat_i <= {24'h0, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      end_sim();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic ins(input logic [2:0] v);
    {cmp1_i, port_b4_data_i, timer_output_level_i} <= v;
    repeat (6) @(posedge clk_i);
  endtask
  initial
  begin
    {clk_i, wb_we_i, wb_cyc_i, wb_stb_i, cmp1_i, cmp2_i, wait_mode_i, stop_mode_i} = 8'h00;
    {port_b4_data_i, timer_output_level_i, wb_adr_i, wb_dat_i} = 66'h0;
    wb_sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (mux_e[i])
    begin
      wb(ADDR_MUX, 1'b1, mux_v[i]);
      chk({pin_channel_select_o, supply_select_o, divided_sample_select_o, diode_select_o, diode_bias_en_o},
        mux_e[i]);
      ins(3'h0);
      chk(pin_channel_select_o, mux_e[i][7:4]);
    end
    foreach (ctl_v[i])
    begin
      wb(ADDR_CTRL, 1'b1, ctl_v[i]);
      chk({charge_source_en_o, discharge_en_o} & ctl_m[i], ctl_e[i]);
    end
    wb(ADDR_CTRL, 1'b1, 8'h10);
    for (int v = 0; v < 8; v++)
    begin
      ins(v[2:0]);
      chk({compare_output_pin_oe_o, compare_output_pin_o, capture_input_o}, {2'b10 | (v != 0), v[2]});
    end
    ins(3'h0);
    wb(ADDR_STATUS, 1'b1, 8'h03);
    wb(ADDR_IRQ, 1'b1, 8'h01);
    cmp2_i <= 1'b1;
    wait_mode_i <= 1'b1;
    ins(3'h0);
    chk({irq_o, wake_o}, 2'h0);
    ins(3'h4);
    chk({irq_o, wake_o}, 2'h3);
    stop_mode_i <= 1'b1;
    ins(3'h4);
    chk({irq_o, wake_o}, 2'h2);
    wb(ADDR_STATUS, 1'b1, 8'h01);
    wb(ADDR_STATUS, 1'b0, 8'h00);
    chk({q, irq_o}, 9'h004);
    wb(4'h3, 1'b0, 8'h00);
    chk(q, 8'h00);
    end_sim();
  end
endmodule // analog_mux_comparator_control_tb
`default_nettype wire
